/* File: qdts_pkg.sv */
// constants, field layouts and state encodings of the quad dac two-wire slave
// assumes nothing of its surroundings; shared by the slave and its channel store
package qdts_pkg;

	// ==========================================================
	// widths
	localparam int CHAN_W   = 2;
	localparam int NUM_CHAN = 4;
	localparam int DATA_W   = 12;
	localparam int PD_W     = 2;

	// ==========================================================
	// address byte and control byte layout
	localparam logic [4:0] ADDR_FIXED    = 5'h13;	// fixed upper five address bits
	localparam int         CTRL_KIND_BIT = 0;	// data_kind_bit
	localparam int         CTRL_CH_LSB   = 1;	// two channel-select bits
	localparam int         CTRL_LOAD_LSB = 4;	// two load-select bits
	localparam logic [7:0] CTRL_RST      = 8'h00;

	// ==========================================================
	// data byte layout
	localparam int         PD_MSB   = 7;	// powerdown_mode_hi position
	localparam int         PD_LSB   = 6;	// powerdown_mode_lo position
	localparam logic [5:0] PD_FILL  = 6'h3F;	// low bits of powerdown_readback_byte
	localparam logic [3:0] LO_FILL  = 4'h0;	// don't-care nibble of lower_data_byte
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_FULL = 4'h8;

	// ==========================================================
	// state encodings
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_RX     = 6'h02,
		ST_RX_ACK = 6'h04,
		ST_TX     = 6'h08,
		ST_TX_ACK = 6'h10,
		ST_IGNORE = 6'h20
	} qdts_state_t;

	typedef enum logic [3:0] {
		PH_ADDR = 4'h1,
		PH_CTRL = 4'h2,
		PH_HI   = 4'h4,
		PH_LO   = 4'h8
	} qdts_phase_t;

	typedef enum logic [2:0] {
		TB_PD = 3'h1,
		TB_HI = 3'h2,
		TB_LO = 3'h4
	} qdts_txbyte_t;

endpackage

/* File: qdts_store.sv */
// per-channel readback store: powerdown bits and conversion data
// assumes one write port and one read port on the same clock; cleared by reset
`timescale 1ns/1ns
`default_nettype none
module qdts_store #(
	parameter int CHAN_W   = qdts_pkg::CHAN_W,
	parameter int NUM_CHAN = qdts_pkg::NUM_CHAN,
	parameter int DATA_W   = qdts_pkg::DATA_W,
	parameter int PD_W     = qdts_pkg::PD_W
) (
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic [CHAN_W-1:0] wr_addr,
	input  wire logic              wr_data_en,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_pd_en,
	input  wire logic [PD_W-1:0]   wr_pd,
	input  wire logic [CHAN_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data,
	output logic      [PD_W-1:0]   rd_pd
);

	logic [DATA_W-1:0] data_mem      [NUM_CHAN];
	logic [PD_W-1:0]   pd_mem        [NUM_CHAN];
	logic [DATA_W-1:0] next_data_mem [NUM_CHAN];
	logic [PD_W-1:0]   next_pd_mem   [NUM_CHAN];

	// ==========================================================
	// write path: data and powerdown fields update separately
	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			next_data_mem[i] = data_mem[i];
			next_pd_mem[i]   = pd_mem[i];
		end
		if (wr_data_en) begin
			next_data_mem[wr_addr] = wr_data;
		end
		if (wr_pd_en) begin
			next_pd_mem[wr_addr] = wr_pd;
		end
	end

	// clearing at reset gives zero readback before any write
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				data_mem[i] <= '0;
				pd_mem[i]   <= '0;
			end
			rd_data <= '0;
			rd_pd   <= '0;
		end else begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				data_mem[i] <= next_data_mem[i];
				pd_mem[i]   <= next_pd_mem[i];
			end
			rd_data <= data_mem[rd_addr];	// registered read, one cycle latency
			rd_pd   <= pd_mem[rd_addr];
		end
	end

endmodule
`default_nettype wire

/* File: qdts_slave.sv */
// two-wire slave protocol engine of a quad 12-bit dac
// assumes scl and sda pins are oversampled by sys_clk, at least eight clocks per bit
`timescale 1ns/1ns
`default_nettype none
module qdts_slave (
	input  wire logic                          sys_clk,
	input  wire logic                          nrst,
	input  wire logic                          scl_in,
	input  wire logic                          sda_in,
	output logic                               sda_out,
	output logic                               sda_oe,
	input  wire logic                          addr_pin_hi,
	input  wire logic                          addr_pin_lo,
	output logic                               upd_strobe,
	output logic      [qdts_pkg::CHAN_W-1:0]   upd_channel,
	output logic      [1:0]                    upd_load_sel,
	output logic                               upd_is_powerdown,
	output logic      [qdts_pkg::DATA_W-1:0]   upd_data,
	output logic      [qdts_pkg::PD_W-1:0]     upd_powerdown
);

	// ==========================================================
	// pin synchronisers and bus condition detection
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [1:0] prev;	// previous {scl, sda} after synchronisation
	logic       scl;
	logic       sda;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;

	// only sync2 reads sync1, so metastability stays in the first stage
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sync1 <= 4'hF;
			sync2 <= 4'hF;
			prev  <= 2'h3;
		end else begin
			sync1 <= {scl_in, sda_in, addr_pin_hi, addr_pin_lo};
			sync2 <= sync1;
			prev  <= sync2[3:2];
		end
	end

	// edges and start/stop conditions from the synchronised levels
	assign scl        = sync2[3];
	assign sda        = sync2[2];
	assign scl_rise   = scl & ~prev[1];
	assign scl_fall   = ~scl & prev[1];
	assign start_seen = scl & prev[1] & prev[0] & ~sda;
	assign stop_seen  = scl & prev[1] & ~prev[0] & sda;

	// ==========================================================
	// protocol state
	qdts_pkg::qdts_state_t  state;
	qdts_pkg::qdts_state_t  next_state;
	qdts_pkg::qdts_phase_t  phase;
	qdts_pkg::qdts_phase_t  next_phase;
	qdts_pkg::qdts_txbyte_t txb;
	qdts_pkg::qdts_txbyte_t next_txb;
	logic [3:0]             bit_cnt;
	logic [3:0]             next_bit_cnt;
	logic [7:0]             shreg;
	logic [7:0]             next_shreg;
	logic [7:0]             ctrl;
	logic [7:0]             next_ctrl;
	logic [7:0]             hi_byte;
	logic [7:0]             next_hi_byte;
	logic                   rd_dir;
	logic                   next_rd_dir;
	logic                   master_ack;
	logic                   next_master_ack;
	logic                   next_sda_oe;
	logic                   next_upd_strobe;
	logic [1:0]             next_upd_channel;
	logic [1:0]             next_upd_load_sel;
	logic                   next_upd_is_powerdown;
	logic [11:0]            next_upd_data;
	logic [1:0]             next_upd_powerdown;

	// store interface
	logic                   st_wr_data_en;
	logic                   st_wr_pd_en;
	logic [11:0]            st_rd_data;
	logic [1:0]             st_rd_pd;
	logic                   kind_pd;
	logic [1:0]             ch_sel;

	assign kind_pd = ctrl[qdts_pkg::CTRL_KIND_BIT];
	assign ch_sel  = ctrl[qdts_pkg::CTRL_CH_LSB +: 2];

	// byte the slave transmits for a given position in the readback
	function automatic logic [7:0] tx_byte(
		input qdts_pkg::qdts_txbyte_t b,
		input logic [1:0]             pd,
		input logic [11:0]            d
	);
		logic [7:0] r;
		r = {d[3:0], qdts_pkg::LO_FILL};
		if (b == qdts_pkg::TB_PD) begin
			r = {pd, qdts_pkg::PD_FILL};
		end else if (b == qdts_pkg::TB_HI) begin
			r = d[11:4];
		end
		return r;
	endfunction

	// next-state logic: one pass per sys_clk, acting on detected scl edges
	always_comb begin
		next_state            = state;
		next_phase            = phase;
		next_txb              = txb;
		next_bit_cnt          = bit_cnt;
		next_shreg            = shreg;
		next_ctrl             = ctrl;
		next_hi_byte          = hi_byte;
		next_rd_dir           = rd_dir;
		next_master_ack       = master_ack;
		next_upd_strobe       = 1'b0;
		next_upd_channel      = upd_channel;
		next_upd_load_sel     = upd_load_sel;
		next_upd_is_powerdown = upd_is_powerdown;
		next_upd_data         = upd_data;
		next_upd_powerdown    = upd_powerdown;
		st_wr_data_en         = 1'b0;
		st_wr_pd_en           = 1'b0;
		if (start_seen) begin
			// a repeated start always restarts at the address byte
			next_state   = qdts_pkg::ST_RX;
			next_phase   = qdts_pkg::PH_ADDR;
			next_bit_cnt = '0;
		end else if (stop_seen) begin
			next_state = qdts_pkg::ST_IDLE;
		end else begin
			unique case (state)
				qdts_pkg::ST_IDLE: begin
				end
				qdts_pkg::ST_RX: begin
					if (scl_rise && bit_cnt != qdts_pkg::BIT_FULL) begin
						next_shreg   = {shreg[6:0], sda};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == qdts_pkg::BIT_FULL) begin
						next_state = qdts_pkg::ST_RX_ACK;
						unique case (phase)
							qdts_pkg::PH_ADDR: begin
								// high-speed code never matches, so it goes unanswered
								if (shreg[7:1] != {qdts_pkg::ADDR_FIXED, sync2[1:0]}) begin
									next_state = qdts_pkg::ST_IGNORE;
								end
								next_rd_dir = shreg[0];
							end
							qdts_pkg::PH_CTRL: next_ctrl = shreg;
							qdts_pkg::PH_HI:   next_hi_byte = shreg;
							qdts_pkg::PH_LO: begin
							end
						endcase
					end
				end
				qdts_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						next_bit_cnt = '0;
						next_state   = qdts_pkg::ST_RX;
						unique case (phase)
							qdts_pkg::PH_ADDR: begin
								next_phase = qdts_pkg::PH_CTRL;
								if (rd_dir) begin
									// first byte depends on the kind in the last control byte
									next_state = qdts_pkg::ST_TX;
									next_txb   = kind_pd ? qdts_pkg::TB_PD : qdts_pkg::TB_HI;
									next_shreg = tx_byte(next_txb, st_rd_pd, st_rd_data);
								end
							end
							qdts_pkg::PH_CTRL: next_phase = qdts_pkg::PH_HI;
							qdts_pkg::PH_HI:   next_phase = qdts_pkg::PH_LO;
							qdts_pkg::PH_LO: begin
								// update lands on the fall that closes this ack
								next_upd_strobe       = 1'b1;
								next_upd_channel      = ch_sel;
								next_upd_load_sel     = ctrl[qdts_pkg::CTRL_LOAD_LSB +: 2];
								next_upd_is_powerdown = kind_pd;
								if (kind_pd) begin
									st_wr_pd_en        = 1'b1;
									next_upd_powerdown = hi_byte[qdts_pkg::PD_MSB:qdts_pkg::PD_LSB];
									next_upd_data      = st_rd_data;
									next_state         = qdts_pkg::ST_IGNORE;
								end else begin
									st_wr_data_en      = 1'b1;
									st_wr_pd_en        = 1'b1;
									next_upd_powerdown = 2'h0;
									next_upd_data      = {hi_byte, shreg[7:4]};
									next_phase         = qdts_pkg::PH_HI;
								end
							end
						endcase
					end
				end
				qdts_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == qdts_pkg::BIT_LAST) begin
							next_state   = qdts_pkg::ST_TX_ACK;
							next_bit_cnt = '0;
						end else begin
							next_shreg   = {shreg[6:0], 1'b1};
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				qdts_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						next_master_ack = ~sda;
					end else if (scl_fall) begin
						// a nack or the last byte ends our part of the read
						if (master_ack && txb != qdts_pkg::TB_LO) begin
							next_state = qdts_pkg::ST_TX;
							next_txb   = (txb == qdts_pkg::TB_PD) ? qdts_pkg::TB_HI
							                                      : qdts_pkg::TB_LO;
							next_shreg = tx_byte(next_txb, st_rd_pd, st_rd_data);
						end else begin
							next_state = qdts_pkg::ST_IGNORE;
						end
					end
				end
				qdts_pkg::ST_IGNORE: begin
				end
				default: next_state = qdts_pkg::ST_IDLE;
			endcase
		end
		// pull low for ack, or for a zero bit while transmitting
		next_sda_oe = (next_state == qdts_pkg::ST_RX_ACK) ||
		              (next_state == qdts_pkg::ST_TX && !next_shreg[7]);
	end

	// protocol registers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state            <= qdts_pkg::ST_IDLE;
			phase            <= qdts_pkg::PH_ADDR;
			txb              <= qdts_pkg::TB_HI;
			bit_cnt          <= '0;
			shreg            <= 8'hFF;
			ctrl             <= qdts_pkg::CTRL_RST;
			hi_byte          <= 8'h00;
			rd_dir           <= 1'b0;
			master_ack       <= 1'b0;
			sda_oe           <= 1'b0;
			upd_strobe       <= 1'b0;
			upd_channel      <= 2'h0;
			upd_load_sel     <= 2'h0;
			upd_is_powerdown <= 1'b0;
			upd_data         <= 12'h000;
			upd_powerdown    <= 2'h0;
		end else begin
			state            <= next_state;
			phase            <= next_phase;
			txb              <= next_txb;
			bit_cnt          <= next_bit_cnt;
			shreg            <= next_shreg;
			ctrl             <= next_ctrl;
			hi_byte          <= next_hi_byte;
			rd_dir           <= next_rd_dir;
			master_ack       <= next_master_ack;
			sda_oe           <= next_sda_oe;
			upd_strobe       <= next_upd_strobe;
			upd_channel      <= next_upd_channel;
			upd_load_sel     <= next_upd_load_sel;
			upd_is_powerdown <= next_upd_is_powerdown;
			upd_data         <= next_upd_data;
			upd_powerdown    <= next_upd_powerdown;
		end
	end

	assign sda_out = 1'b0;	// open drain: only ever pulls low

	// ==========================================================
	// channel readback store
	qdts_store u_store (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.wr_addr    (ch_sel),
		.wr_data_en (st_wr_data_en),
		.wr_data    ({hi_byte, shreg[7:4]}),
		.wr_pd_en   (st_wr_pd_en),
		.wr_pd      (kind_pd ? hi_byte[qdts_pkg::PD_MSB:qdts_pkg::PD_LSB] : 2'h0),
		.rd_addr    (ch_sel),
		.rd_data    (st_rd_data),
		.rd_pd      (st_rd_pd)
	);

endmodule
`default_nettype wire

/* File: qdts_slave_assertions.sv */
// port checker for the two-wire slave of the quad dac
// assumes one sys_clk domain with synchronous active-low nrst; bound below
`timescale 1ns/1ns
`default_nettype none
module qdts_slave_chk (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic        addr_pin_hi,
	input wire logic        addr_pin_lo,
	input wire logic        upd_strobe,
	input wire logic [1:0]  upd_channel,
	input wire logic [1:0]  upd_load_sel,
	input wire logic        upd_is_powerdown,
	input wire logic [11:0] upd_data,
	input wire logic [1:0]  upd_powerdown
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// helper: cycles of continuous low drive, catches a stuck pull
	logic [7:0] oe_run;
	logic [7:0] next_oe_run;
	always_comb begin
		next_oe_run = sda_oe ? oe_run + 8'h01 : 8'h00;
	end
	always_ff @(posedge sys_clk) begin
		oe_run <= nrst ? next_oe_run : 8'h00;
	end
	// ==========================================================
	// port rules
	a_out_low: assert property (sda_out == 1'b0)
		else $error("sda_out not low");
	a_reset_clear: assert property ($rose(nrst) |-> !sda_oe && upd_data == 12'h000 && upd_powerdown == 2'h0)
		else $error("outputs not cleared by reset");
	a_strobe_gap: assert property (upd_strobe |=> !upd_strobe [*8])
		else $error("update strobe too long or too close");
	a_upd_hold: assert property (!upd_strobe |-> $stable({upd_channel, upd_load_sel, upd_is_powerdown, upd_data, upd_powerdown}))
		else $error("update outputs moved without strobe");
	a_pd_clear: assert property (upd_strobe && !upd_is_powerdown |-> upd_powerdown == 2'h0)
		else $error("normal write kept powerdown bits");
	a_upd_after_ack: assert property (upd_strobe |-> $past(sda_oe, 2))
		else $error("update without acknowledge");
	a_stop_quiet: assert property (scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*8])
		else $error("slave drives after stop");
	a_oe_steady: assert property (scl_in [*2] |-> $stable(sda_oe))
		else $error("sda changed while scl high");
	a_oe_bounded: assert property (oe_run < 8'hA0)
		else $error("sda held low too long");
	c_pd_upd: cover property (upd_strobe && upd_is_powerdown);
	c_norm_upd: cover property (upd_strobe && !upd_is_powerdown);
	c_drive: cover property ($rose(sda_oe));
endmodule
bind qdts_slave qdts_slave_chk chk (
	.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo),
	.upd_strobe(upd_strobe), .upd_channel(upd_channel), .upd_load_sel(upd_load_sel),
	.upd_is_powerdown(upd_is_powerdown), .upd_data(upd_data), .upd_powerdown(upd_powerdown)
);
`default_nettype wire

/* File: qdts_master.sv */
// two-wire bus master model facing the slave
// assumes sda is resolved outside with a pull-up; scl idles high
`timescale 1ns/1ns
`default_nettype none
module qdts_master (
	input  wire logic       sys_clk,
	input  wire logic       sda,
	output var  logic       scl,
	output var  logic       sda_low,
	output var  logic       res_valid,
	output var  logic [7:0] res_val
);
	// ==========================================================
	// hp is half an scl period in sys_clk cycles; raise it for a slow master
	int hp = 4;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_valid = 1'b0;
		res_val = 8'h00;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// one bit; scl moves only here and in start and stop, so it stands still between frames
	task automatic bit_io(input logic b, output logic r);
		tick(hp / 2);
		sda_low <= ~b;
		tick(hp - hp / 2);
		scl <= 1'b1;
		tick(hp / 2);
		r = sda;
		tick(hp - hp / 2);
		scl <= 1'b0;
	endtask
	// start or repeated start; extra wait lets a late ack release first
	task automatic start();
		sda_low <= 1'b0;
		tick(hp + 2);
		scl <= 1'b1;
		tick(hp);
		sda_low <= 1'b1;
		tick(hp);
		scl <= 1'b0;
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(hp + 2);
		scl <= 1'b1;
		tick(hp);
		sda_low <= 1'b0;
		tick(hp);
	endtask
	task automatic report(input logic [7:0] v);
		res_val <= v;
		res_valid <= 1'b1;
		tick(1);
		res_valid <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		report({7'h00, r});
	endtask
	task automatic rd(input logic last);
		logic [7:0] v;
		logic       r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(last, r);
		report(v);
	endtask
endmodule
`default_nettype wire

/* File: tb_qdts_slave.sv */
// self-checking bench for the quad dac two-wire slave
// assumes qdts_master as bus partner and a pull-up on sda
`timescale 1ns/1ns
`default_nettype none
module tb_qdts_slave;
	logic              sys_clk = 1'b0;
	logic              nrst = 1'b0;
	logic              addr_pin_hi;
	logic              addr_pin_lo;
	wire  logic        scl, sda, sda_low, sda_out, sda_oe, res_valid, upd_strobe, upd_is_powerdown;
	wire  logic [1:0]  upd_channel, upd_load_sel, upd_powerdown;
	wire  logic [11:0] upd_data;
	wire  logic [7:0]  res_val;
	int                n_errors = 0;
	int                total_checks = 0;
	integer            seed = 32'hA6C39B71;
	logic       [7:0]  exp_res[$];
	logic       [18:0] exp_upd[$];
	logic       [11:0] md[4] = '{default: 12'h000};
	logic       [1:0]  mp[4] = '{default: 2'h0};
	logic       [7:0]  ctl;
	logic       [1:0]  m;
	// ==========================================================
	// clock, wire and instances
	always #20 sys_clk = ~sys_clk;
	assign sda = ~(sda_low | sda_oe);
	qdts_slave dut (
		.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .addr_pin_hi(addr_pin_hi), .addr_pin_lo(addr_pin_lo),
		.upd_strobe(upd_strobe), .upd_channel(upd_channel), .upd_load_sel(upd_load_sel),
		.upd_is_powerdown(upd_is_powerdown), .upd_data(upd_data), .upd_powerdown(upd_powerdown)
	);
	qdts_master mst (
		.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
		.res_valid(res_valid), .res_val(res_val)
	);
	// ==========================================================
	// comparison
	task automatic tally(input logic bad, input logic [18:0] e, input logic [18:0] g);
		total_checks++;
		if (bad) begin
			n_errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
		tally(g !== e, 19'(e), 19'(g));
	endtask
	task automatic chk_upd(input logic [18:0] e, input logic [18:0] g);
		tally(g !== e, e, g);
	endtask
	// oldest note against each result; an empty queue gives unknowns that never match
	always @(posedge sys_clk) begin
		if (res_valid === 1'b1)
			chk_byte(exp_res.size() > 0 ? exp_res.pop_front() : 8'hX, res_val);
		if (upd_strobe === 1'b1)
			chk_upd(exp_upd.size() > 0 ? exp_upd.pop_front() : 19'hX, {upd_channel, upd_load_sel, upd_is_powerdown, upd_data, upd_powerdown});
	end
	// ==========================================================
	// bus sequences
	function automatic logic [7:0] adr(input logic rw);
		return {5'h13, addr_pin_hi, addr_pin_lo, rw};
	endfunction
	task automatic put(input logic [7:0] b, input logic nak);
		exp_res.push_back({7'h00, nak});
		mst.wr(b);
	endtask
	task automatic sel(input logic [1:0] ch, input logic k, input logic [1:0] ld);
		ctl = {2'h0, ld, 1'b0, ch, k};
		mst.start();
		put(adr(1'b0), 1'b0);
		put(ctl, 1'b0);
	endtask
	task automatic pair(input logic [11:0] d);
		put(d[11:4], 1'b0);
		md[ctl[2:1]] = d;
		mp[ctl[2:1]] = 2'h0;
		exp_upd.push_back({ctl[2:1], ctl[5:4], 1'b0, d, 2'h0});
		put({d[3:0], 4'($random(seed))}, 1'b0);
	endtask
	task automatic ex_rd(input logic [7:0] v, input logic last);
		exp_res.push_back(v);
		mst.rd(last);
	endtask
	task automatic rdb();
		mst.start();
		put(adr(1'b1), 1'b0);
		if (ctl[0])
			ex_rd({mp[ctl[2:1]], 6'h3F}, 1'b0);
		ex_rd(md[ctl[2:1]][11:4], 1'b0);
		ex_rd({md[ctl[2:1]][3:0], 4'h0}, 1'b1);
		mst.stop();
	endtask
	task automatic end_sim();
		if (exp_res.size() + exp_upd.size() > 0)
			n_errors++;
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// watchdog: the whole run needs well under a third of this
	initial begin
		#1000000;
		n_errors++;
		end_sim();
	end
	initial begin
		// straps change on a rising edge like every other input; reset still spans six edges
		@(posedge sys_clk);
		addr_pin_hi <= 1'($random(seed));
		addr_pin_lo <= 1'($random(seed));
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		sel(2'h2, 1'b0, 2'h0);
		rdb();
		// high-speed code is refused, then restart into a burst
		mst.start();
		put({5'h01, 3'($random(seed))}, 1'b1);
		sel(2'($random(seed)), 1'b0, {1'b0, 1'($random(seed))});
		repeat (3) pair(12'($random(seed)));
		mst.stop();
		for (int i = 0; i < 4; i++) begin
			sel(2'(i), 1'b0, {1'b0, 1'($random(seed))});
			pair(12'($random(seed)));
			rdb();
		end
		// slow master: powerdown write, third byte refused, three-byte readback
		mst.hp = 8;
		m = 2'($random(seed));
		sel(2'($random(seed)), 1'b1, 2'h1);
		mp[ctl[2:1]] = m;
		put({m, 6'h00}, 1'b0);
		exp_upd.push_back({ctl[2:1], 2'h1, 1'b1, md[ctl[2:1]], m});
		put({4'h0, 4'($random(seed))}, 1'b0);
		put(8'h00, 1'b1);
		rdb();
		mst.hp = 4;
		// lone high byte cut by a restart writes nothing
		sel(2'h1, 1'b0, 2'h0);
		put(8'hA5, 1'b0);
		sel(2'h1, 1'b0, 2'h0);
		rdb();
		mst.start();
		put({5'h13, ~addr_pin_hi, addr_pin_lo, 1'b0}, 1'b1);
		put(8'h00, 1'b1);
		mst.stop();
		repeat (20) @(posedge sys_clk);
		end_sim();
	end
endmodule
`default_nettype wire
